// ==== verilog/psl_param_sets.sv ====
// Module: active, factory and user parameter sets with save, load and startup load
//
// Overview of operation
// - Active set lives in flops, cleared and rebuilt at every reset.
// - Software writes to parameter words change only the active set.
// - Factory set is fixed constant storage, never writable.
// - User set sits in storage that reset does not touch.
// - Exactly one user slot, reached with selector value user slot zero.
// - Save copies every active word into the user slot.
// - Load overwrites every active word from the selected stored set.
// - After load the loaded values drive the camera as active set.
// - Startup choice register picks factory or user slot zero.
// - Every reset loads the set named by the startup choice.
// - Set holds gain, exposure, format, image region, packet settings, overwrite.
// - Set also holds trigger, line, pattern, auto and white balance settings.
`timescale 1ns/1ps
module psl_param_sets
	import psl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire psl_addr_t addr,
	input wire psl_word_t wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output psl_word_t rd_data,
	// Parameters to the camera
	output psl_set_t active_set,
	output logic busy
);
	// ----------------------------------------------------------------
	// Storage that survives reset
	// ----------------------------------------------------------------
	// Both keep their contents across reset; the declared values model a
	// freshly programmed part and are the only power-on content. A single
	// clocked process writes each, so the storage has one driver.
	psl_set_t user_mem = PSL_FACTORY_SET;
	logic startup_set_choice = STARTUP_FACTORY_DEFAULT;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic is_param(input psl_addr_t a);
		return (a[PSL_AW-1:8] == REG_PARAM_BASE[PSL_AW-1:8]) && (a[1:0] == 2'b00)
			&& (int'(a[7:2]) < PSL_NW);
	endfunction

	function automatic psl_idx_t param_idx(input psl_addr_t a);
		return a[7:2];
	endfunction

	psl_regs_s cur;
	psl_regs_s next_cur;
	logic save_req;
	logic load_req;
	logic last_word;

	always_comb begin
		save_req = wr_en && (addr == REG_COMMAND) && wr_data[CMD_SAVE_BIT];
		load_req = wr_en && (addr == REG_COMMAND) && wr_data[CMD_LOAD_BIT] && !save_req;
		last_word = (cur.idx == psl_idx_t'(PSL_NW - 1));
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		case (cur.state)
			ST_IDLE: begin
				next_cur.busy = 1'b0;
				if (wr_en && is_param(addr)) begin
					next_cur.active[param_idx(addr)] = wr_data;
				end
				if (wr_en && (addr == REG_SELECT)) begin
					next_cur.config_set_select = wr_data[0];
				end
				if (save_req) begin
					// The factory slot cannot be a save target
					if (cur.config_set_select == USER_SLOT_ZERO) begin
						next_cur.state = ST_SAVE;
						next_cur.idx = '0;
						next_cur.busy = 1'b1;
						next_cur.refused = 1'b0;
					end else begin
						next_cur.refused = 1'b1;
					end
				end else if (load_req) begin
					next_cur.state = ST_LOAD;
					next_cur.src = cur.config_set_select;
					next_cur.idx = '0;
					next_cur.busy = 1'b1;
					next_cur.refused = 1'b0;
				end
			end
			ST_SAVE: begin
				// Register writes and commands are ignored while a copy runs
				next_cur.idx = cur.idx + psl_idx_t'(1);
				if (last_word) begin
					next_cur.state = ST_IDLE;
					next_cur.busy = 1'b0;
				end
			end
			ST_LOAD: begin
				// Staged first so the camera never sees a half-loaded set
				if (cur.src == USER_SLOT_ZERO) begin
					next_cur.stage[cur.idx] = user_mem[cur.idx];
				end else begin
					next_cur.stage[cur.idx] = PSL_FACTORY_SET[cur.idx];
				end
				next_cur.idx = cur.idx + psl_idx_t'(1);
				if (last_word) begin
					next_cur.state = ST_COMMIT;
				end
			end
			ST_COMMIT: begin
				next_cur.active = cur.stage;
				next_cur.state = ST_IDLE;
				next_cur.busy = 1'b0;
			end
			default: begin
				next_cur.state = ST_IDLE;
				next_cur.busy = 1'b0;
			end
		endcase

		// Read data stand only in the cycle after the strobe
		next_cur.rd_data = '0;
		if (rd_en) begin
			if (addr == REG_SELECT) begin
				next_cur.rd_data = {31'h0000_0000, cur.config_set_select};
			end else if (addr == REG_STARTUP) begin
				next_cur.rd_data = {31'h0000_0000, startup_set_choice};
			end else if (addr == REG_STATUS) begin
				next_cur.rd_data[STAT_BUSY_BIT] = cur.busy;
				next_cur.rd_data[STAT_REFUSED_BIT] = cur.refused;
			end else if (is_param(addr)) begin
				next_cur.rd_data = cur.active[param_idx(addr)];
			end
		end

		if (reset) begin
			// Active set is volatile: cleared, then rebuilt from the startup set
			next_cur.active = '0;
			next_cur.stage = '0;
			next_cur.state = ST_LOAD;
			next_cur.src = startup_set_choice;
			next_cur.idx = '0;
			next_cur.busy = 1'b1;
			next_cur.refused = 1'b0;
			next_cur.config_set_select = SELECT_RESET;
			next_cur.rd_data = '0;
		end
	end

	always_ff @(posedge clk) begin
		cur <= next_cur;
	end

	// ----------------------------------------------------------------
	// Non-volatile writes
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset && cur.state == ST_SAVE) begin
			user_mem[cur.idx] <= cur.active[cur.idx];
		end
		// Startup choice is taken only while idle, like every other register
		if (!reset && cur.state == ST_IDLE && wr_en && addr == REG_STARTUP) begin
			startup_set_choice <= wr_data[0];
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = cur.rd_data;
		active_set = cur.active;
		busy = cur.busy;
	end
endmodule

// ==== common/psl_pkg.sv ====
// Package: constants, register map and carrier types of the parameter set loader
package psl_pkg;
	// ----------------------------------------------------------------
	// Parameter set geometry
	// ----------------------------------------------------------------
	localparam int PSL_NW = 48;
	localparam int PSL_DW = 32;
	localparam int PSL_IW = 6;
	localparam int PSL_AW = 10;
	typedef logic [PSL_DW-1:0] psl_word_t;
	typedef logic [PSL_IW-1:0] psl_idx_t;
	typedef logic [PSL_AW-1:0] psl_addr_t;
	typedef logic [PSL_NW-1:0][PSL_DW-1:0] psl_set_t;

	// ----------------------------------------------------------------
	// Word index of each parameter inside a set
	// ----------------------------------------------------------------
	localparam int PI_GAIN = 0, PI_EXPOSURE = 1, PI_PIXEL_FORMAT = 2, PI_OFFSET_X = 3;
	localparam int PI_OFFSET_Y = 4, PI_WIDTH = 5, PI_HEIGHT = 6, PI_PACKET_SIZE = 7;
	localparam int PI_PACKET_DELAY = 8, PI_TRIG_MODE = 9, PI_TRIG_SOURCE = 10;
	localparam int PI_TRIG_POLARITY = 11, PI_TRIG_DELAY = 12, PI_TRIG_FILT_RISE = 13;
	localparam int PI_TRIG_FILT_FALL = 14, PI_LINE_MODE = 15, PI_LINE_INVERT = 16;
	localparam int PI_LINE_SOURCE = 17, PI_USER_OUTPUT = 18, PI_FB_OVERWRITE = 19;
	localparam int PI_TEST_PATTERN = 20, PI_EXPECTED_GRAY = 21, PI_EXPOSURE_AUTO = 22;
	localparam int PI_AE_MAX = 23, PI_AE_MIN = 24, PI_GAIN_AUTO = 25, PI_AG_MAX = 26;
	localparam int PI_AG_MIN = 27, PI_AA_OFFSET_X = 28, PI_AA_OFFSET_Y = 29;
	localparam int PI_AA_WIDTH = 30, PI_AA_HEIGHT = 31, PI_WB_AUTO = 32, PI_WB_LAMP = 33;
	localparam int PI_WB_OFFSET_X = 34, PI_WB_OFFSET_Y = 35, PI_WB_WIDTH = 36;
	localparam int PI_WB_HEIGHT = 37, PI_RATIO_R = 38, PI_RATIO_G = 39, PI_RATIO_B = 40;

	// ----------------------------------------------------------------
	// Factory set, fixed in the netlist (plain defaults)
	// ----------------------------------------------------------------
	function automatic psl_set_t psl_factory();
		psl_set_t s;
		s = '0;
		s[PI_WIDTH] = 32'h0000_0100;
		s[PI_HEIGHT] = 32'h0000_0100;
		s[PI_PACKET_SIZE] = 32'h0000_05dc;
		s[PI_EXPECTED_GRAY] = 32'h0000_0078;
		s[PI_RATIO_R] = 32'h0000_0100;
		s[PI_RATIO_G] = 32'h0000_0100;
		s[PI_RATIO_B] = 32'h0000_0100;
		return s;
	endfunction
	localparam psl_set_t PSL_FACTORY_SET = psl_factory();

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam psl_addr_t REG_COMMAND = 10'h000;
	localparam psl_addr_t REG_SELECT = 10'h004;
	localparam psl_addr_t REG_STARTUP = 10'h008;
	localparam psl_addr_t REG_STATUS = 10'h00c;
	localparam psl_addr_t REG_PARAM_BASE = 10'h100;
	localparam int CMD_SAVE_BIT = 0;
	localparam int CMD_LOAD_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_REFUSED_BIT = 1;

	// Set selector codes
	localparam logic SET_FACTORY = 1'b0;
	localparam logic USER_SLOT_ZERO = 1'b1;
	localparam logic SELECT_RESET = SET_FACTORY;
	localparam logic STARTUP_FACTORY_DEFAULT = SET_FACTORY;

	// ----------------------------------------------------------------
	// State machine and state record
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LOAD = 4'b0010,
		ST_SAVE = 4'b0100,
		ST_COMMIT = 4'b1000
	} psl_state_e;

	typedef struct packed {
		psl_state_e state;
		psl_idx_t idx;
		logic src;
		logic config_set_select;
		logic refused;
		logic busy;
		psl_word_t rd_data;
		psl_set_t stage;
		psl_set_t active;
	} psl_regs_s;
endpackage

// ==== tb/psl_param_sets_props.sv ====
// Checker: port-level properties of the parameter set loader
`timescale 1ns/1ps
module psl_param_sets_props
	import psl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire psl_addr_t addr,
	input wire psl_word_t wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire psl_word_t rd_data,
	// Camera side
	input wire psl_set_t active_set,
	input wire logic busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ----
	// Load walk: 49 busy cycles, then idle
	// ----
	sequence s_load_cmd;
		wr_en && !busy && addr == REG_COMMAND && wr_data[1:0] == 2'b10;
	endsequence
	sequence s_load_run;
		busy [*8] ##41 busy ##1 !busy;
	endsequence
	a_load_length: assert property (s_load_cmd |=> s_load_run)
		else $error("load length wrong");
	a_startup_busy: assert property ($fell(reset) |-> busy [*8])
		else $error("startup load not busy");
	a_hold_active: assert property (busy ##1 busy |-> $stable(active_set))
		else $error("partial set seen");
	a_rd_idle: assert property (!rd_en |=> rd_data == '0)
		else $error("read data not idle");
	a_unmapped_read: assert property (rd_en && addr == 10'h010 |=> rd_data == '0)
		else $error("unmapped read not zero");
	a_status_idle: assert property (rd_en && !busy && addr == REG_STATUS
		|=> !rd_data[STAT_BUSY_BIT])
		else $error("status busy while idle");
	a_param_write: assert property (wr_en && !busy && addr == REG_PARAM_BASE
		|=> active_set[PI_GAIN] == $past(wr_data))
		else $error("gain write lost");
	a_param_read: assert property (rd_en && !busy && addr == REG_PARAM_BASE
		|=> rd_data == $past(active_set[PI_GAIN]))
		else $error("gain read wrong");
endmodule

// ==== tb/tb_psl_param_sets.sv ====
// Testbench: save, load and startup load of the parameter set loader
`timescale 1ns/1ps
module tb_psl_param_sets import psl_pkg::*;;
	logic clk, reset, wr_en, rd_en, busy;
	psl_addr_t addr;
	psl_word_t wr_data, rd_data, got;
	psl_set_t active_set, user_exp;
	int error_cnt = 0;
	int num_checks = 0;

	psl_param_sets dut (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .active_set(active_set), .busy(busy));

	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	task automatic wr(input psl_addr_t a, input psl_word_t d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		#1;
	endtask

	task automatic rd(input psl_addr_t a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 got = rd_data;
	endtask

	// Bounded so a stuck busy ends in a mismatch, not a hang
	task automatic wait_idle();
		int n = 0;
		#1;
		while (busy !== 1'b0 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(busy === 1'b0, "busy stuck");
	endtask

	task automatic load(input psl_word_t sel);
		wr(REG_SELECT, sel);
		wr(REG_COMMAND, 32'h2);
		wait_idle();
	endtask

	task automatic do_reset();
		@(posedge clk);
		reset <= 1'b1;
		repeat (20) @(posedge clk);
		#1 chk(active_set === '0, "active kept in reset");
		@(posedge clk);
		reset <= 1'b0;
	endtask

	task automatic t_startup();
		wait_idle();
		chk(active_set === PSL_FACTORY_SET, "startup set");
		rd(REG_STATUS);
		chk(got === 32'h0, "status");
		rd(10'h010);
		chk(got === 32'h0, "unmapped");
		$display("test startup done");
	endtask

	task automatic t_save_load();
		for (int i = 0; i < PSL_NW; i++) begin
			user_exp[i] = 32'h00a0_0000 + i;
			wr(REG_PARAM_BASE + psl_addr_t'(4 * i), user_exp[i]);
		end
		chk(active_set === user_exp, "param writes");
		rd(REG_PARAM_BASE);
		chk(got === user_exp[PI_GAIN], "read back");
		wr(REG_SELECT, 32'h1);
		wr(REG_COMMAND, 32'h1);
		wait_idle();
		load(32'h0);
		chk(active_set === PSL_FACTORY_SET, "factory load");
		load(32'h1);
		chk(active_set === user_exp, "user load");
		$display("test save_load done");
	endtask

	task automatic t_refused();
		wr(REG_PARAM_BASE, 32'h33);
		wr(REG_SELECT, 32'h0);
		wr(REG_COMMAND, 32'h1);
		rd(REG_STATUS);
		chk(got[STAT_REFUSED_BIT] === 1'b1, "save refused");
		wr(REG_COMMAND, 32'h2);
		wr(REG_PARAM_BASE, 32'h55);
		wait_idle();
		chk(active_set === PSL_FACTORY_SET, "write in load");
		load(32'h1);
		chk(active_set === user_exp, "user set kept");
		$display("test refused done");
	endtask

	task automatic t_restart();
		wr(REG_STARTUP, 32'h1);
		wr(REG_PARAM_BASE, 32'h77);
		do_reset();
		wait_idle();
		chk(active_set === user_exp, "startup user");
		$display("test restart done");
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		addr = '0;
		wr_data = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		reset = 1'b1;
		do_reset();
		t_startup();
		t_save_load();
		t_refused();
		t_restart();
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end
endmodule

bind psl_param_sets psl_param_sets_props u_props (.clk(clk), .reset(reset), .addr(addr),
	.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
	.active_set(active_set), .busy(busy));
